// >>> verilog/laser_hutch_interlock.sv
`timescale 1ns/1ps
module laser_hutch_interlock
	import hutch_pkg::*;
#(
	parameter tcnt_t TICK_DIV_P   = tcnt_t'(TICK_DIV),
	parameter tcnt_t WARN_TICKS_P = tcnt_t'(WARN_TICKS),
	parameter tcnt_t ESC_TICKS_P  = tcnt_t'(ESC_TICKS),
	parameter tcnt_t DOOR_TICKS_P = tcnt_t'(DOOR_TICKS)
) (
	input  wire logic              clk_sys_i,          // 40 MHz system clock
	input  wire logic              reset_n_i,          // Async reset, active low
	input  wire logic              estop_in_i,         // Inner emergency stop, high pressed
	input  wire logic              estop_out_i,        // Outer emergency stop, high pressed
	input  wire logic              sweep_begin_i,      // Inner sweep-begin button
	input  wire logic              sweep_finish_i,     // Outer sweep-finish button
	input  wire logic              disarm_i,           // Orderly-disarm button
	input  wire logic              open_in_i,          // Inner shutter open button
	input  wire logic              open_out_i,         // Outer shutter open button
	input  wire logic              close_in_i,         // Inner shutter close button
	input  wire logic              close_out_i,        // Outer shutter close button
	input  wire logic              escort_in_i,        // Inner escorted-entry button
	input  wire logic              escort_out_i,       // Outer escorted-entry button
	input  wire logic              door_closed_i,      // Door or curtain closed switch
	input  wire logic              key_enable_i,       // Lockout key in, enabling position
	input  wire logic              reset_key_i,        // Responsible-person reset key
	input  wire logic              sns_open_i,         // Shutter open position sensor
	input  wire logic              sns_closed_i,       // Shutter closed position sensor
	input  wire logic              psel_i,             // APB select
	input  wire logic              penable_i,          // APB enable
	input  wire logic              pwrite_i,           // APB write
	input  wire logic [ADDR_W-1:0] paddr_i,            // APB byte address
	input  wire logic [31:0]       pwdata_i,           // APB write data
	output logic      [31:0]       prdata_o,           // APB read data
	output logic                   pready_o,           // APB ready
	output logic                   pslverr_o,          // APB error, unmapped
	output logic                   psu_enable_o,       // Laser supply enable
	output logic                   shutter_open_o,     // Shutter open command
	output logic                   sounder_o,          // Warning sounder
	output logic                   secure_lamp_o,      // Area-secure lamp
	output logic                   sign_inner_o,       // Inner interlocked sign
	output logic                   sign_outer_o,       // Outer interlocked sign
	output logic                   esc_lamp_in_o,      // Inner escort button lamp
	output logic                   esc_lamp_out_o      // Outer escort button lamp
);
	cond_if cif ();

	input_conditioner u_cond (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.c         (cif.cond)
	);

	assign cif.raw = {sns_closed_i, sns_open_i, reset_key_i, key_enable_i, door_closed_i,
		escort_out_i, escort_in_i, close_out_i, close_in_i, open_out_i, open_in_i,
		disarm_i, sweep_finish_i, sweep_begin_i, estop_out_i, estop_in_i};

	// Tick divider and edge detection
	tcnt_t             div_ff, nxt_div;
	logic              tick_ff, nxt_tick;
	logic [IN_NUM-1:0] prev_ff, lvl, rise;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_div  = div_ff + tcnt_t'(1);
		if (div_ff == TICK_DIV_P - tcnt_t'(1)) begin
			nxt_div  = '0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
			prev_ff <= '0;
		end else begin
			div_ff  <= nxt_div;
			tick_ff <= nxt_tick;
			prev_ff <= lvl;
		end
	end

	assign cif.tick = tick_ff;
	assign lvl      = cif.level;
	assign rise     = lvl & ~prev_ff;

	logic estop, door_shut, key_ok, conflict, noclose;
	assign estop     = lvl[IN_ESTOP_IN] | lvl[IN_ESTOP_OUT];
	assign door_shut = lvl[IN_DOOR_SHUT];
	assign key_ok    = lvl[IN_KEY_OK];
	assign conflict  = lvl[IN_SNS_OPEN] & lvl[IN_SNS_CLOSED];

	// Main sequencer
	state_e               state_ff, nxt_state;
	tcnt_t                tmr_ff, nxt_tmr;
	tcnt_t                door_ff, nxt_door;
	logic                 esc_ff, nxt_esc, esc_inner_ff, nxt_esc_inner;
	logic                 breach_ff, nxt_breach;
	logic [CAUSE_W-1:0]   cause_ff, nxt_cause, evt;
	logic                 esc_start, ctrl_variant_b_ff;

	always_comb begin
		nxt_state     = state_ff;
		nxt_tmr       = tmr_ff;
		nxt_door      = door_ff;
		nxt_esc       = esc_ff;
		nxt_esc_inner = esc_inner_ff;
		nxt_breach    = breach_ff;
		nxt_cause     = cause_ff;
		esc_start     = 1'b0;
		evt           = '0;
		evt[CAUSE_ESTOP]    = estop;
		evt[CAUSE_CONFLICT] = conflict;
		evt[CAUSE_NOCLOSE]  = noclose;
		case (state_ff)
			ST_IDLE: begin
				if (key_ok && rise[IN_SWEEP_BEG]) begin
					nxt_state = ST_SWEEP;
				end
			end
			ST_SWEEP: begin
				if (!key_ok || rise[IN_DISARM]) begin
					nxt_state = ST_IDLE;
				end else if (rise[IN_SWEEP_FIN] && door_shut) begin
					nxt_state = ST_WARN;
					nxt_tmr   = '0;
				end
			end
			ST_WARN: begin
				if (!key_ok || rise[IN_DISARM] || !door_shut) begin
					nxt_state = ST_IDLE;
				end else if (tick_ff) begin
					if (tmr_ff == WARN_TICKS_P - tcnt_t'(1)) begin
						nxt_state = ST_ARMED;
					end else begin
						nxt_tmr = tmr_ff + tcnt_t'(1);
					end
				end
			end
			ST_ARMED: begin
				if (!key_ok || rise[IN_DISARM]) begin
					nxt_state = ST_IDLE;
					nxt_esc   = 1'b0;
				end else if (!esc_ff) begin
					nxt_tmr  = '0;
					nxt_door = '0;
					if (rise[IN_ESC_OUT] || rise[IN_ESC_IN]) begin
						nxt_esc       = 1'b1;
						nxt_esc_inner = !rise[IN_ESC_OUT];
						esc_start     = 1'b1;
					end else if (!door_shut) begin
						evt[CAUSE_BREACH] = 1'b1;
						nxt_breach        = 1'b1;
					end
				end else begin
					// Far-side press ends the escort
					if (esc_inner_ff ? rise[IN_ESC_OUT] : rise[IN_ESC_IN]) begin
						nxt_esc = 1'b0;
					end else if (tick_ff) begin
						if (tmr_ff == ESC_TICKS_P - tcnt_t'(1)) begin
							nxt_esc = 1'b0;
						end else begin
							nxt_tmr = tmr_ff + tcnt_t'(1);
						end
					end
					if (door_shut) begin
						nxt_door = '0;
					end else if (tick_ff) begin
						if (door_ff == DOOR_TICKS_P - tcnt_t'(1)) begin
							evt[CAUSE_OVERSTAY] = 1'b1;
							nxt_esc             = 1'b0;
						end else begin
							nxt_door = door_ff + tcnt_t'(1);
						end
					end
				end
			end
			ST_DUMP: begin
				if (rise[IN_RESET_KEY] && !estop) begin
					nxt_state  = ST_IDLE;
					nxt_cause  = '0;
					nxt_breach = 1'b0;
				end
			end
			default: nxt_state = ST_DUMP;
		endcase
		// Any event forces the dump and wins over the reset key
		if (|evt) begin
			nxt_state = ST_DUMP;
			nxt_esc   = 1'b0;
			nxt_cause = nxt_cause | evt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff     <= ST_IDLE;
			tmr_ff       <= '0;
			door_ff      <= '0;
			esc_ff       <= 1'b0;
			esc_inner_ff <= 1'b0;
			breach_ff    <= 1'b0;
			cause_ff     <= '0;
		end else begin
			state_ff     <= nxt_state;
			tmr_ff       <= nxt_tmr;
			door_ff      <= nxt_door;
			esc_ff       <= nxt_esc;
			esc_inner_ff <= nxt_esc_inner;
			breach_ff    <= nxt_breach;
			cause_ff     <= nxt_cause;
		end
	end

	// Shutter sequencer
	shut_e shut_ff, nxt_shut;
	tcnt_t beep_ff, nxt_beep;
	tcnt_t clw_ff, nxt_clw;
	logic  open_req, close_req;

	assign open_req  = rise[IN_OPEN_IN] | rise[IN_OPEN_OUT];
	assign close_req = rise[IN_CLOSE_IN] | rise[IN_CLOSE_OUT];
	assign noclose   = (clw_ff == tcnt_t'(CLOSE_TICKS - 1));

	always_comb begin
		nxt_shut = shut_ff;
		nxt_beep = beep_ff;
		nxt_clw  = clw_ff;
		case (shut_ff)
			SH_CLOSED: begin
				if (open_req && state_ff == ST_ARMED) begin
					nxt_shut = SH_BEEP1;
					nxt_beep = '0;
				end
			end
			SH_BEEP1, SH_GAP1, SH_BEEP2, SH_GAP2: begin
				if (tick_ff) begin
					if (beep_ff == tcnt_t'(BEEP_TICKS - 1)) begin
						nxt_beep = '0;
						nxt_shut = shut_e'(shut_ff + 3'h1);
					end else begin
						nxt_beep = beep_ff + tcnt_t'(1);
					end
				end
			end
			SH_OPEN: nxt_shut = SH_OPEN;
			default: nxt_shut = SH_CLOSED;
		endcase
		if (close_req || nxt_state != ST_ARMED) begin
			nxt_shut = SH_CLOSED;
		end
		if (esc_start && ctrl_variant_b_ff) begin
			nxt_shut = SH_CLOSED;
		end
		// Closure watchdog while commanded anything but open
		if (shut_ff == SH_OPEN || lvl[IN_SNS_CLOSED]) begin
			nxt_clw = '0;
		end else if (tick_ff && !noclose) begin
			nxt_clw = clw_ff + tcnt_t'(1);
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shut_ff <= SH_CLOSED;
			beep_ff <= '0;
			clw_ff  <= '0;
		end else begin
			shut_ff <= nxt_shut;
			beep_ff <= nxt_beep;
			clw_ff  <= nxt_clw;
		end
	end

	assign psu_enable_o   = (state_ff == ST_ARMED);
	assign secure_lamp_o  = (state_ff == ST_ARMED);
	assign sign_inner_o   = (state_ff == ST_ARMED);
	assign sign_outer_o   = (state_ff == ST_ARMED);
	assign shutter_open_o = (shut_ff == SH_OPEN);
	assign sounder_o      = (state_ff == ST_WARN) || shut_ff == SH_BEEP1
		|| shut_ff == SH_BEEP2 || breach_ff;
	assign esc_lamp_out_o = esc_ff & ~esc_inner_ff;
	assign esc_lamp_in_o  = esc_ff & esc_inner_ff;

	// APB slave, zero wait states
	logic [31:0] rdata_ff, nxt_rdata;
	logic        nxt_variant_b, mapped, setup, access;

	assign setup     = psel_i & ~penable_i;
	assign access    = psel_i & penable_i;
	assign mapped    = paddr_i == REG_CTRL || paddr_i == REG_STATUS
		|| paddr_i == REG_CAUSE || paddr_i == REG_INPUTS;
	assign pready_o  = 1'b1;
	assign pslverr_o = access & ~mapped;
	assign prdata_o  = rdata_ff;

	always_comb begin
		nxt_rdata     = rdata_ff;
		nxt_variant_b = ctrl_variant_b_ff;
		if (setup && !pwrite_i) begin
			nxt_rdata = '0;
			case (paddr_i)
				REG_CTRL:   nxt_rdata[CTRL_VARIANT_B] = ctrl_variant_b_ff;
				REG_STATUS: begin
					nxt_rdata[STS_STATE_LSB +: 3] = state_ff;
					nxt_rdata[STS_SHUT_LSB +: 3]  = shut_ff;
					nxt_rdata[STS_ESC]            = esc_ff;
					nxt_rdata[STS_ESC_INNER]      = esc_inner_ff;
				end
				REG_CAUSE:  nxt_rdata[CAUSE_W-1:0] = cause_ff;
				REG_INPUTS: nxt_rdata[IN_NUM-1:0]  = lvl;
				default:    nxt_rdata = '0;
			endcase
		end
		if (access && pwrite_i && paddr_i == REG_CTRL) begin
			nxt_variant_b = pwdata_i[CTRL_VARIANT_B];
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_ff          <= '0;
			ctrl_variant_b_ff <= CTRL_RESET;
		end else begin
			rdata_ff          <= nxt_rdata;
			ctrl_variant_b_ff <= nxt_variant_b;
		end
	end
endmodule

// >>> shared/hutch_pkg.sv
// Notes on behaviour
// - Either emergency stop drops arming, removes supply enable and closes the shutter.
// - After a dump only the reset key returns the controller to idle.
// - Inner sweep-begin press starts arming; outer sweep-finish with door closed follows.
// - Accepted sweep-finish sounds the sounder continuously for 30 seconds.
// - After the warning: armed, secure lamp and signs lit, laser work enabled.
// - Orderly-disarm press returns to idle with laser work disabled.
// - Door open while armed without escort sounds warning and needs the reset key.
// - Open and close presses from either station drive the shutter.
// - Two short beeps precede every shutter opening.
// - Armed outer escort press lights its lamp and lets the door open.
// - Escort ends on the far-side escort press or when its window expires.
// - Door open over 30 seconds during escort cancels it and dumps.
// - Second variant: starting escort closes the shutter until a new open press.
// - Escort can start from inside; each escort lamp lights while active.
// - Interlocked signs lit exactly while armed.
// - Lockout key off or removed prevents arming and operating.
// - Shutter sensor conflict or failure to close acts as an emergency stop.
package hutch_pkg;
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned TICK_HZ        = 1000;
	localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
	localparam int unsigned WARN_S         = 30;
	localparam int unsigned ESC_WINDOW_S   = 30;
	localparam int unsigned DOOR_OPEN_S    = 30;
	localparam int unsigned BEEP_MS        = 150;
	localparam int unsigned CLOSE_LIMIT_MS = 1000;
	localparam int unsigned DEBOUNCE_MS    = 10;
	localparam int unsigned WARN_TICKS     = WARN_S * TICK_HZ;
	localparam int unsigned ESC_TICKS      = ESC_WINDOW_S * TICK_HZ;
	localparam int unsigned DOOR_TICKS     = DOOR_OPEN_S * TICK_HZ;
	localparam int unsigned BEEP_TICKS     = (BEEP_MS * TICK_HZ) / 1000;
	localparam int unsigned CLOSE_TICKS    = (CLOSE_LIMIT_MS * TICK_HZ) / 1000;
	localparam int unsigned DEB_TICKS      = (DEBOUNCE_MS * TICK_HZ + 999) / 1000;

	localparam int TW = 16;
	typedef logic [TW-1:0] tcnt_t;
	typedef logic [3:0]    dcnt_t;

	localparam int IN_ESTOP_IN   = 0;
	localparam int IN_ESTOP_OUT  = 1;
	localparam int IN_SWEEP_BEG  = 2;
	localparam int IN_SWEEP_FIN  = 3;
	localparam int IN_DISARM     = 4;
	localparam int IN_OPEN_IN    = 5;
	localparam int IN_OPEN_OUT   = 6;
	localparam int IN_CLOSE_IN   = 7;
	localparam int IN_CLOSE_OUT  = 8;
	localparam int IN_ESC_IN     = 9;
	localparam int IN_ESC_OUT    = 10;
	localparam int IN_DOOR_SHUT  = 11;
	localparam int IN_KEY_OK     = 12;
	localparam int IN_RESET_KEY  = 13;
	localparam int IN_SNS_OPEN   = 14;
	localparam int IN_SNS_CLOSED = 15;
	localparam int IN_NUM        = 16;

	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] REG_CAUSE  = 12'h008;
	localparam logic [ADDR_W-1:0] REG_INPUTS = 12'h00C;

	localparam int  CTRL_VARIANT_B = 0;
	localparam logic CTRL_RESET    = 1'h0;
	localparam int  STS_STATE_LSB  = 0;
	localparam int  STS_SHUT_LSB   = 4;
	localparam int  STS_ESC        = 8;
	localparam int  STS_ESC_INNER  = 9;

	localparam int CAUSE_ESTOP    = 0;
	localparam int CAUSE_CONFLICT = 1;
	localparam int CAUSE_NOCLOSE  = 2;
	localparam int CAUSE_BREACH   = 3;
	localparam int CAUSE_OVERSTAY = 4;
	localparam int CAUSE_W        = 5;

	typedef enum logic [2:0] {ST_IDLE, ST_SWEEP, ST_WARN, ST_ARMED, ST_DUMP} state_e;
	typedef enum logic [2:0] {SH_CLOSED, SH_BEEP1, SH_GAP1, SH_BEEP2, SH_GAP2, SH_OPEN} shut_e;
endpackage

// >>> shared/cond_if.sv
`timescale 1ns/1ps
interface cond_if;
	import hutch_pkg::*;
	logic [IN_NUM-1:0] raw;
	logic [IN_NUM-1:0] level;
	logic              tick;
	modport cond (input raw, input tick, output level);
	modport ctl  (output raw, output tick, input level);
endinterface

// >>> verilog/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner
	import hutch_pkg::*;
(
	input  wire logic clk_sys_i,   // System clock
	input  wire logic reset_n_i,   // Async reset, active low
	cond_if.cond      c            // Raw pins in, clean levels out
);
	logic [IN_NUM-1:0] sy1_ff, sy2_ff, sy3_ff, lvl_ff, nxt_lvl;
	dcnt_t             cnt_ff [IN_NUM];
	dcnt_t             nxt_cnt [IN_NUM];

	assign c.level = lvl_ff;

	for (genvar i = 0; i < IN_NUM; i++) begin : g_bit
		always_comb begin
			nxt_cnt[i] = cnt_ff[i];
			nxt_lvl[i] = lvl_ff[i];
			// Count only while the synchroniser agrees on a new value
			if (sy2_ff[i] != sy3_ff[i] || sy3_ff[i] == lvl_ff[i]) begin
				nxt_cnt[i] = '0;
			end else if (c.tick) begin
				if (cnt_ff[i] == dcnt_t'(DEB_TICKS - 1)) begin
					nxt_lvl[i] = sy3_ff[i];
					nxt_cnt[i] = '0;
				end else begin
					nxt_cnt[i] = cnt_ff[i] + dcnt_t'(1);
				end
			end
		end

		always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				cnt_ff[i] <= '0;
			end else begin
				cnt_ff[i] <= nxt_cnt[i];
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sy1_ff <= '0;
			sy2_ff <= '0;
			sy3_ff <= '0;
			lvl_ff <= '0;
		end else begin
			sy1_ff <= c.raw;
			sy2_ff <= sy1_ff;
			sy3_ff <= sy2_ff;
			lvl_ff <= nxt_lvl;
		end
	end
endmodule

// >>> test/hutch_properties.sv
`timescale 1ns/1ps
module hutch_properties
	import hutch_pkg::*;
#(
	parameter tcnt_t TICK_DIV_P   = tcnt_t'(TICK_DIV),
	parameter tcnt_t WARN_TICKS_P = tcnt_t'(WARN_TICKS),
	parameter tcnt_t ESC_TICKS_P  = tcnt_t'(ESC_TICKS),
	parameter tcnt_t DOOR_TICKS_P = tcnt_t'(DOOR_TICKS)
) (
	input wire logic clk_sys_i,      // Clock
	input wire logic reset_n_i,      // Reset
	input wire logic estop_in_i,     // Inner stop
	input wire logic estop_out_i,    // Outer stop
	input wire logic door_closed_i,  // Door shut
	input wire logic key_enable_i,   // Lockout key
	input wire logic sns_open_i,     // Open sensor
	input wire logic sns_closed_i,   // Closed sensor
	input wire logic psu_enable_o,   // Supply enable
	input wire logic shutter_open_o, // Shutter command
	input wire logic sounder_o,      // Sounder
	input wire logic secure_lamp_o,  // Secure lamp
	input wire logic sign_inner_o,   // Inner sign
	input wire logic sign_outer_o,   // Outer sign
	input wire logic esc_lamp_in_o,  // Inner escort lamp
	input wire logic esc_lamp_out_o  // Outer escort lamp
);
	localparam int D  = int'(TICK_DIV_P);
	localparam int DL = (int'(DEB_TICKS) + 2) * D + 8;
	localparam int WL = int'(WARN_TICKS_P) * D;
	localparam int EL = (int'(ESC_TICKS_P) + 1) * D + 2;
	localparam int OL = DL + (int'(DOOR_TICKS_P) + 2) * D;
	logic lamp, snd_q;
	int   flt_n, key_n, door_n, warn_n, esc_n, beep_n;
	assign lamp = esc_lamp_in_o | esc_lamp_out_o;
	// Run lengths of conditions, in cycles; beep_n counts sounder rises while armed and shut
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flt_n  <= 0;
			key_n  <= 0;
			door_n <= 0;
			warn_n <= 0;
			esc_n  <= 0;
			beep_n <= 0;
			snd_q  <= 1'b0;
		end else begin
			snd_q  <= sounder_o;
			flt_n  <= (estop_in_i | estop_out_i | (sns_open_i & sns_closed_i)) ? flt_n + 1 : 0;
			key_n  <= key_enable_i ? 0 : key_n + 1;
			door_n <= door_closed_i ? 0 : door_n + 1;
			warn_n <= (sounder_o & !psu_enable_o) ? warn_n + 1 : 0;
			esc_n  <= lamp ? esc_n + 1 : 0;
			beep_n <= (!psu_enable_o | shutter_open_o) ? 0 : beep_n + int'(sounder_o & !snd_q);
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	signs_armed_a: assert property (
		{sign_inner_o, sign_outer_o, secure_lamp_o} == {3{psu_enable_o}})
		else $error("signs and lamp differ from supply enable");
	warn_time_a: assert property (
		$rose(psu_enable_o) |-> warn_n >= WL - D && warn_n <= WL + 2 * D)
		else $error("warning period length wrong");
	shut_armed_a: assert property (
		!psu_enable_o && !$past(psu_enable_o) |-> !shutter_open_o)
		else $error("shutter open while not armed");
	two_beeps_a: assert property ($rose(shutter_open_o) |-> beep_n >= 2)
		else $error("shutter opened without two beeps");
	stop_dump_a: assert property (
		flt_n > DL |-> !psu_enable_o && !shutter_open_o)
		else $error("stop or sensor conflict did not dump");
	key_lockout_a: assert property (key_n > DL |-> !psu_enable_o && !shutter_open_o)
		else $error("running with lockout key off");
	door_breach_a: assert property (
		psu_enable_o && !lamp && door_n > DL |-> ##[0:3] (!psu_enable_o && sounder_o))
		else $error("door breach did not dump with sounder");
	escort_overstay_a: assert property (lamp && door_n > OL |-> ##[0:3] !psu_enable_o)
		else $error("escort door overstay did not dump");
	esc_window_a: assert property (lamp |-> esc_n <= EL)
		else $error("escort outlived its window");
	esc_lamp_a: assert property (
		lamp |-> (esc_lamp_in_o ^ esc_lamp_out_o) && (psu_enable_o || !$rose(lamp)))
		else $error("escort lamp wrong");
	cover property ($rose(psu_enable_o));
	cover property ($rose(shutter_open_o));
	cover property ($rose(esc_lamp_in_o));
	cover property ($rose(esc_lamp_out_o));
endmodule

bind laser_hutch_interlock hutch_properties #(.TICK_DIV_P(TICK_DIV_P),
	.WARN_TICKS_P(WARN_TICKS_P), .ESC_TICKS_P(ESC_TICKS_P), .DOOR_TICKS_P(DOOR_TICKS_P))
	i_hutch_properties (.*);

// >>> test/shutter_model.sv
`timescale 1ns/1ps
module shutter_model (
	input  wire logic clk_sys_i,   // Clock
	input  wire logic drive_i,     // Open command
	input  wire logic slow_i,      // Long travel
	input  wire logic conflict_i,  // Both sensors on
	input  wire logic stuck_i,     // Blade will not close
	output logic      sns_open_o,  // At open stop
	output logic      sns_closed_o // At closed stop
);
	int travel;
	int pos_n = 0;
	assign travel = slow_i ? 200 : 3;
	// Blade position, 0 at the closed stop
	always_ff @(posedge clk_sys_i) begin
		if (drive_i && pos_n < travel) begin
			pos_n <= pos_n + 1;
		end else if (!drive_i && pos_n > 0 && !stuck_i) begin
			pos_n <= pos_n - 1;
		end
	end
	assign sns_open_o   = conflict_i || (pos_n >= travel);
	assign sns_closed_o = conflict_i || (pos_n == 0);
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
	import hutch_pkg::*;
	localparam int D  = 4;
	localparam int ET = 100;
	localparam int DH = 64;
	logic              clk_sys_i, reset_n_i, psel, penable, pwrite, serr, pready, pslverr;
	logic [IN_NUM-1:0] pin;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, r;
	logic              psu, shut, snd, sec, sgi, sgo, eli, elo, sno, snc, slow, conf, stuck;
	int                err_total, samples_checked, b;
	wire  [3:0]        outs = {psu, sec, sgi, sgo};

	laser_hutch_interlock #(.TICK_DIV_P(tcnt_t'(D)), .WARN_TICKS_P(tcnt_t'(50)),
		.ESC_TICKS_P(tcnt_t'(ET)), .DOOR_TICKS_P(tcnt_t'(30))) i_laser_hutch_interlock (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .estop_in_i(pin[IN_ESTOP_IN]),
		.estop_out_i(pin[IN_ESTOP_OUT]), .sweep_begin_i(pin[IN_SWEEP_BEG]),
		.sweep_finish_i(pin[IN_SWEEP_FIN]), .disarm_i(pin[IN_DISARM]),
		.open_in_i(pin[IN_OPEN_IN]), .open_out_i(pin[IN_OPEN_OUT]),
		.close_in_i(pin[IN_CLOSE_IN]), .close_out_i(pin[IN_CLOSE_OUT]),
		.escort_in_i(pin[IN_ESC_IN]), .escort_out_i(pin[IN_ESC_OUT]),
		.door_closed_i(pin[IN_DOOR_SHUT]), .key_enable_i(pin[IN_KEY_OK]),
		.reset_key_i(pin[IN_RESET_KEY]), .sns_open_i(sno), .sns_closed_i(snc),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.psu_enable_o(psu), .shutter_open_o(shut), .sounder_o(snd), .secure_lamp_o(sec),
		.sign_inner_o(sgi), .sign_outer_o(sgo), .esc_lamp_in_o(eli), .esc_lamp_out_o(elo));
	shutter_model i_shutter_model (.clk_sys_i(clk_sys_i), .drive_i(shut), .slow_i(slow),
		.conflict_i(conf), .stuck_i(stuck), .sns_open_o(sno), .sns_closed_o(snc));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [3:0] outs_f(input logic armed);
		return {4{armed}};
	endfunction
	function automatic logic [31:0] cause_f(input int c);
		return 32'h1 << c;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'b1;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_total++;
			summarize();
		end
		r = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		cyc(1);
	endtask
	task automatic wait_st(input state_e st);
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (r[2:0] !== st && n < 3000);
		chk(r[2:0], st);
		if (r[2:0] !== st) summarize();
	endtask
	task automatic cause_is(input int c);
		apb(1'b0, REG_CAUSE, 32'h0);
		chk(r[CAUSE_W-1:0], cause_f(c));
	endtask
	task automatic press(input int k);
		pin[k] <= 1'b1;
		cyc(DH);
		pin[k] <= 1'b0;
		cyc(DH);
	endtask
	task automatic clear_dump();
		press(IN_RESET_KEY);
		wait_st(ST_IDLE);
	endtask
	task automatic arm();
		slow <= 1'($urandom);
		press(IN_SWEEP_BEG);
		press(IN_SWEEP_FIN);
		chk({snd, psu}, 2'b10);
		wait_st(ST_ARMED);
		chk({outs, snd}, {outs_f(1'b1), 1'b0});
	endtask
	task automatic open_sh();
		int   n, k;
		logic s;
		n = 0;
		k = 0;
		b = $urandom_range(1) ? IN_OPEN_IN : IN_OPEN_OUT;
		pin[b] <= 1'b1;
		while (shut !== 1'b1 && n < 5000) begin
			s = snd;
			cyc(1);
			n++;
			k += int'(snd === 1'b1 && s === 1'b0);
			if (n == DH) pin[b] <= 1'b0;
		end
		chk(k, 2);
		chk(shut, 1'b1);
		if (shut !== 1'b1) summarize();
		cyc(DH);
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		int v;
		void'($urandom(11));
		pin = '0;
		pin[IN_DOOR_SHUT] = 1'b1;
		pin[IN_KEY_OK] = 1'b1;
		{reset_n_i, psel, penable, pwrite, slow, conf, stuck} = '0;
		paddr = '0;
		pwdata = '0;
		err_total = 0;
		samples_checked = 0;
		cyc(2);
		reset_n_i <= 1'b1;
		cyc(1);
		chk({outs, snd, shut, eli, elo}, 8'h00);
		apb(1'b0, 12'hFF0, 32'h0);
		chk(serr, 1'b1);
		chk(r, 32'h0);
		chk(pready, 1'b1);
		v = $urandom;
		apb(1'b1, REG_CTRL, v);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(r[0], v[0]);
		$display("test registers done");
		pin[IN_KEY_OK] <= 1'b0;
		press(IN_SWEEP_BEG);
		press(IN_SWEEP_FIN);
		chk({snd, psu}, 2'b00);
		wait_st(ST_IDLE);
		pin[IN_KEY_OK] <= 1'b1;
		cyc(DH);
		apb(1'b0, REG_INPUTS, 32'h0);
		chk(r, 32'({snc, sno, pin[IN_RESET_KEY:0]}));
		pin[IN_SWEEP_BEG] <= 1'b1;
		cyc(8);
		pin[IN_SWEEP_BEG] <= 1'b0;
		cyc(DH);
		wait_st(ST_IDLE);
		$display("test lockout done");
		arm();
		open_sh();
		press($urandom_range(1) ? IN_CLOSE_IN : IN_CLOSE_OUT);
		chk(shut, 1'b0);
		press(IN_DISARM);
		chk({outs, shut}, 5'h00);
		wait_st(ST_IDLE);
		$display("test arm and disarm done");
		arm();
		for (v = 0; v < 2; v++) begin
			apb(1'b1, REG_CTRL, v);
			open_sh();
			press(IN_ESC_OUT);
			chk({elo, eli, psu, shut}, {3'b101, ~v[0]});
			pin[IN_DOOR_SHUT] <= 1'b0;
			cyc(DH);
			pin[IN_DOOR_SHUT] <= 1'b1;
			cyc(DH);
			press(IN_ESC_IN);
			chk({elo, eli, psu, shut}, {3'b001, ~v[0]});
			press(IN_CLOSE_IN);
		end
		press(IN_ESC_IN);
		chk({eli, elo}, 2'b10);
		cyc(ET * D);
		chk({eli, psu}, 2'b01);
		press(IN_ESC_OUT);
		pin[IN_DOOR_SHUT] <= 1'b0;
		wait_st(ST_DUMP);
		pin[IN_DOOR_SHUT] <= 1'b1;
		cause_is(CAUSE_OVERSTAY);
		press(IN_SWEEP_BEG);
		wait_st(ST_DUMP);
		clear_dump();
		$display("test escort done");
		arm();
		pin[IN_DOOR_SHUT] <= 1'b0;
		wait_st(ST_DUMP);
		chk(snd, 1'b1);
		cause_is(CAUSE_BREACH);
		pin[IN_DOOR_SHUT] <= 1'b1;
		cyc(DH);
		clear_dump();
		chk(snd, 1'b0);
		$display("test breach done");
		arm();
		open_sh();
		b = $urandom_range(1) ? IN_ESTOP_IN : IN_ESTOP_OUT;
		pin[b] <= 1'b1;
		wait_st(ST_DUMP);
		chk({outs, shut}, 5'h00);
		cause_is(CAUSE_ESTOP);
		press(IN_RESET_KEY);
		wait_st(ST_DUMP);
		pin[b] <= 1'b0;
		cyc(DH);
		clear_dump();
		$display("test stop done");
		arm();
		conf <= 1'b1;
		wait_st(ST_DUMP);
		cause_is(CAUSE_CONFLICT);
		conf <= 1'b0;
		cyc(DH);
		clear_dump();
		arm();
		open_sh();
		stuck <= 1'b1;
		press(IN_CLOSE_OUT);
		wait_st(ST_DUMP);
		cause_is(CAUSE_NOCLOSE);
		stuck <= 1'b0;
		cyc(4 * DH);
		clear_dump();
		$display("test shutter fault done");
		summarize();
	end
endmodule
